// file: src/rxp_pkg.sv
package rxp_pkg;

  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_SLEEP = 8'h04;
  localparam logic [7:0] ADDR_LIMIT = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0c;
  localparam logic [7:0] ADDR_STARTUP = 8'h10;

  localparam int CTRL_POLL_EN_BIT = 0;
  localparam int CTRL_RX_CLR_BIT = 1;
  localparam int SLEEP_VAL_LSB = 0;
  localparam int SLEEP_EXT_BIT = 8;
  localparam int LIM_MIN_LSB = 0;
  localparam int LIM_MAX_LSB = 8;
  localparam int NBIT_LSB = 16;
  localparam int PLL_TIME_LSB = 0;
  localparam int SIG_TIME_LSB = 16;

  localparam logic [4:0] SLEEP_RESET = 5'h01;
  localparam logic [5:0] LIM_MIN_RESET = 6'h0e;
  localparam logic [5:0] LIM_MAX_RESET = 6'h18;
  localparam logic [1:0] NBIT_RESET = 2'h1;
  localparam logic [15:0] PLL_TIME_RESET = 16'h0010;
  localparam logic [15:0] SIG_TIME_RESET = 16'h0010;

  localparam int SLEEP_UNIT = 1024;
  localparam logic [3:0] SLEEP_EXT_X1 = 4'h1;
  localparam logic [3:0] SLEEP_EXT_X8 = 4'h8;
  localparam logic [4:0] CHECKS_PER_BIT_SEL = 5'h06;

  typedef enum logic [2:0] {
    RXP_OFF, RXP_SLEEP, RXP_PLL, RXP_SIG, RXP_CHECK, RXP_RECEIVE
  } rxp_phase_e;

  typedef struct packed {
    logic poll_en;
    logic [4:0] sleep_val;
    logic sleep_extend_sel;
    logic [5:0] lim_min;
    logic [5:0] lim_max;
    logic [1:0] nbit_sel;
    logic [15:0] pll_time;
    logic [15:0] sig_time;
  } rxp_cfg_s;

  typedef struct packed {
    rxp_cfg_s cfg;
    rxp_phase_e phase;
    logic [22:0] sleep_cnt;
    logic [15:0] start_cnt;
    logic [5:0] interval_count_value;
    logic [4:0] pass_cnt;
    logic demod_last;
    logic edge_seen;
    logic [31:0] prdata;
    logic pll_en;
    logic sig_en;
  } rxp_state_s;

endpackage

// file: src/rxp_polling.sv
`timescale 1ns/100ps
module rxp_polling
  import rxp_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic base_clk_tick,
  input wire logic check_clk_tick,
  input wire logic pll_lock,
  input wire logic demod_out,
  output logic pll_en,
  output logic sig_proc_en,
  output logic rx_active,
  output logic receiving
);

  rxp_state_s s;
  rxp_state_s next_s;

  logic wr_en;
  logic rd_en;
  logic mapped;
  logic [3:0] ext_factor;
  logic [22:0] sleep_target;
  logic [4:0] checks_needed;
  logic edge_now;

  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;
  assign mapped = (paddr == ADDR_CTRL) || (paddr == ADDR_SLEEP) || (paddr == ADDR_LIMIT) ||
                  (paddr == ADDR_STATUS) || (paddr == ADDR_STARTUP);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  assign ext_factor = s.cfg.sleep_extend_sel ? SLEEP_EXT_X8 : SLEEP_EXT_X1;
  // Sleep length in base clock ticks
  assign sleep_target = 23'(s.cfg.sleep_val) * 23'(SLEEP_UNIT) * 23'(ext_factor);
  assign checks_needed = 5'(s.cfg.nbit_sel) * CHECKS_PER_BIT_SEL;
  assign edge_now = demod_out != s.demod_last;

  always_comb begin
    next_s = s;
    next_s.prdata = 32'h0000_0000;

    if (wr_en) begin
      if (paddr == ADDR_CTRL) begin
        next_s.cfg.poll_en = pwdata[CTRL_POLL_EN_BIT];
      end else if (paddr == ADDR_SLEEP) begin
        next_s.cfg.sleep_val = pwdata[SLEEP_VAL_LSB +: 5];
        next_s.cfg.sleep_extend_sel = pwdata[SLEEP_EXT_BIT];
      end else if (paddr == ADDR_LIMIT) begin
        next_s.cfg.lim_min = pwdata[LIM_MIN_LSB +: 6];
        next_s.cfg.lim_max = pwdata[LIM_MAX_LSB +: 6];
        next_s.cfg.nbit_sel = pwdata[NBIT_LSB +: 2];
      end else if (paddr == ADDR_STARTUP) begin
        next_s.cfg.pll_time = pwdata[PLL_TIME_LSB +: 16];
        next_s.cfg.sig_time = pwdata[SIG_TIME_LSB +: 16];
      end
    end

    if (rd_en) begin
      if (paddr == ADDR_CTRL) begin
        next_s.prdata[CTRL_POLL_EN_BIT] = s.cfg.poll_en;
      end else if (paddr == ADDR_SLEEP) begin
        next_s.prdata[SLEEP_VAL_LSB +: 5] = s.cfg.sleep_val;
        next_s.prdata[SLEEP_EXT_BIT] = s.cfg.sleep_extend_sel;
      end else if (paddr == ADDR_LIMIT) begin
        next_s.prdata[LIM_MIN_LSB +: 6] = s.cfg.lim_min;
        next_s.prdata[LIM_MAX_LSB +: 6] = s.cfg.lim_max;
        next_s.prdata[NBIT_LSB +: 2] = s.cfg.nbit_sel;
      end else if (paddr == ADDR_STATUS) begin
        next_s.prdata[2:0] = 3'(s.phase);
        next_s.prdata[8 +: 5] = s.pass_cnt;
        next_s.prdata[16 +: 6] = s.interval_count_value;
      end else if (paddr == ADDR_STARTUP) begin
        next_s.prdata[PLL_TIME_LSB +: 16] = s.cfg.pll_time;
        next_s.prdata[SIG_TIME_LSB +: 16] = s.cfg.sig_time;
      end
    end

    next_s.demod_last = demod_out;

    case (s.phase)
      RXP_OFF: begin
        next_s.pll_en = 1'b0;
        next_s.sig_en = 1'b0;
        if (s.cfg.poll_en) begin
          next_s.phase = RXP_SLEEP;
          next_s.sleep_cnt = '0;
        end
      end
      RXP_SLEEP: begin
        // Demodulator input is ignored here
        next_s.pll_en = 1'b0;
        next_s.sig_en = 1'b0;
        if (base_clk_tick) begin
          next_s.sleep_cnt = s.sleep_cnt + 23'h000001;
        end
        if (s.sleep_cnt >= sleep_target) begin
          next_s.phase = RXP_PLL;
          next_s.pll_en = 1'b1;
          next_s.start_cnt = '0;
        end
      end
      RXP_PLL: begin
        next_s.pll_en = 1'b1;
        if (pll_lock) begin
          next_s.phase = RXP_SIG;
          next_s.sig_en = 1'b1;
          next_s.start_cnt = '0;
        end
      end
      RXP_SIG: begin
        next_s.start_cnt = s.start_cnt + 16'h0001;
        if (s.start_cnt >= s.cfg.sig_time) begin
          next_s.phase = RXP_CHECK;
          next_s.interval_count_value = '0;
          next_s.pass_cnt = '0;
          next_s.edge_seen = 1'b0;
        end
      end
      RXP_CHECK: begin
        if (checks_needed == 5'h00 || s.pass_cnt >= checks_needed) begin
          next_s.phase = RXP_RECEIVE;
        end else if (edge_now) begin
          if (!s.edge_seen) begin
            // First edge only starts the interval
            next_s.edge_seen = 1'b1;
            next_s.interval_count_value = '0;
          end else if (s.interval_count_value < s.cfg.lim_min) begin
            next_s.phase = RXP_SLEEP;
            next_s.sleep_cnt = '0;
          end else begin
            next_s.pass_cnt = s.pass_cnt + 5'h01;
            next_s.interval_count_value = '0;
          end
        end else if (s.edge_seen && s.interval_count_value >= s.cfg.lim_max) begin
          next_s.phase = RXP_SLEEP;
          next_s.sleep_cnt = '0;
        end else if (s.edge_seen && check_clk_tick) begin
          next_s.interval_count_value = s.interval_count_value + 6'h01;
        end
        if (next_s.phase == RXP_SLEEP) begin
          next_s.pll_en = 1'b0;
          next_s.sig_en = 1'b0;
        end
      end
      RXP_RECEIVE: begin
        if (wr_en && paddr == ADDR_CTRL && pwdata[CTRL_RX_CLR_BIT]) begin
          // Drop the enables with the phase so the active flag never disagrees
          next_s.phase = RXP_OFF;
          next_s.pll_en = 1'b0;
          next_s.sig_en = 1'b0;
        end
      end
      default: begin
        next_s.phase = RXP_OFF;
      end
    endcase

    // Polling disabled drops the sequencer back to idle from any phase except RXP_RECEIVE
    if (!s.cfg.poll_en && s.phase != RXP_RECEIVE && s.phase != RXP_OFF) begin
      next_s.phase = RXP_OFF;
      next_s.pll_en = 1'b0;
      next_s.sig_en = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
      s.phase <= RXP_OFF;
      s.cfg.sleep_val <= SLEEP_RESET;
      s.cfg.lim_min <= LIM_MIN_RESET;
      s.cfg.lim_max <= LIM_MAX_RESET;
      s.cfg.nbit_sel <= NBIT_RESET;
      s.cfg.pll_time <= PLL_TIME_RESET;
      s.cfg.sig_time <= SIG_TIME_RESET;
    end else begin
      s <= next_s;
    end
  end

  assign prdata = s.prdata;
  assign pll_en = s.pll_en;
  assign sig_proc_en = s.sig_en;
  assign rx_active = s.phase == RXP_SIG || s.phase == RXP_CHECK || s.phase == RXP_RECEIVE;
  assign receiving = s.phase == RXP_RECEIVE;

endmodule

// file: tb/rx_polling_bitcheck_test.sv
`timescale 1ns/100ps
module rx_polling_bitcheck_test
  import rxp_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, q;
  logic pready, pslverr, pll_lock, demod_out, pll_en, sig_proc_en, rx_active, receiving, e;
  logic [7:0] gap = 8'h0f;
  logic [3:0] lock_dly = 4'h3;
  int err_total = 0;
  int compares = 0;
  int seed = 65470;
  int n, slp;
  int rv[6] = '{0, 1, 32'h1180e, 0, 32'h100010, 0};
  int sc[6][4] = '{'{1, 0, 1, 15}, '{0, 0, 0, 15}, '{2, 0, 3, 0}, '{1, 1, 2, 15}, '{1, 0, 1, 5}, '{1, 0, 1, 40}};
  always #20 pclk = ~pclk;
  rxp_polling DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .base_clk_tick(1'b1), .check_clk_tick(1'b1), .pll_lock(pll_lock), .demod_out(demod_out),
    .pll_en(pll_en), .sig_proc_en(sig_proc_en), .rx_active(rx_active), .receiving(receiving));
  rxp_tx_model TX (.pclk(pclk), .pll_en(pll_en), .gap(gap), .lock_dly(lock_dly), .pll_lock(pll_lock),
    .demod_out(demod_out));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(negedge pclk);
    q = prdata;
  endtask
  task automatic sleep_len(input int exp);
    int m;
    m = 0;
    while (pll_en !== 1'b1 && m < 70000) begin
      @(negedge pclk);
      m++;
    end
    chk(32'(m >= exp && m <= exp + 4), 32'h1);
  endtask
  task automatic conclude;
    $display("Comparisons %0d, mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    #(40 * 40000);
    err_total++;
    conclude();
  end
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, 8'(i * 4), 32'h0);
      chk(q, rv[i]);
      chk(32'(e), 32'(i == 5));
    end
    apb(1'b1, ADDR_STARTUP, 32'h00040004);
    for (int k = 0; k < 6; k++) begin
      gap <= sc[k][3] != 0 ? 8'(sc[k][3]) : 8'(12 + {$random(seed)} % 7);
      lock_dly <= 4'(1 + {$random(seed)} % 15);
      apb(1'b1, ADDR_SLEEP, 32'(sc[k][1] * 256 + sc[k][0]));
      apb(1'b1, ADDR_LIMIT, 32'(sc[k][2] * 65536 + 20 * 256 + 10));
      apb(1'b1, ADDR_CTRL, 32'h1);
      slp = sc[k][0] * 1024 * (sc[k][1] != 0 ? 8 : 1);
      sleep_len(slp);
      n = 0;
      while (receiving !== 1'b1 && pll_en === 1'b1 && n < 3000) begin
        @(negedge pclk);
        n++;
      end
      chk(32'(receiving), 32'(gap > 10 && gap < 20));
      if (receiving === 1'b1) begin
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk(q & 32'h1f07, 32'(sc[k][2] * 1536 + 5));
      end else begin
        sleep_len(slp);
      end
      apb(1'b1, ADDR_CTRL, 32'h2);
    end
    conclude();
  end
endmodule

// file: tb/rxp_polling_props.sv
`timescale 1ns/100ps
module rxp_polling_props
  import rxp_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pll_lock,
  input wire logic pll_en,
  input wire logic sig_proc_en,
  input wire logic rx_active,
  input wire logic receiving
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic clr;
  assign clr = psel && penable && pwrite && paddr == ADDR_CTRL && pwdata[CTRL_RX_CLR_BIT];
  a_sig_needs_pll: assert property (sig_proc_en |-> pll_en) else $error("sig on, pll off");
  a_lock_gate: assert property (pll_en && !sig_proc_en && !pll_lock |=> !sig_proc_en) else $error("no lock");
  a_sleep_first: assert property (!pll_en |=> !sig_proc_en) else $error("pll skipped");
  a_fail_sleep: assert property ($fell(sig_proc_en) |-> !pll_en) else $error("no sleep");
  a_recv_from_chk: assert property ($rose(receiving) |-> $past(sig_proc_en)) else $error("bad entry");
  a_recv_enabled: assert property (receiving |-> sig_proc_en && rx_active) else $error("rx off");
  a_recv_holds: assert property (receiving && !clr |=> receiving) else $error("rx lost");
  a_active_match: assert property (rx_active == sig_proc_en) else $error("active flag");
endmodule
bind rxp_polling rxp_polling_props PROPS (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pll_lock(pll_lock), .pll_en(pll_en),
  .sig_proc_en(sig_proc_en), .rx_active(rx_active), .receiving(receiving));

// file: tb/rxp_tx_model.sv
`timescale 1ns/100ps
module rxp_tx_model (
  input wire logic pclk,
  input wire logic pll_en,
  input wire logic [7:0] gap,
  input wire logic [3:0] lock_dly,
  output logic pll_lock,
  output logic demod_out
);
  logic [7:0] gcnt = 8'h00;
  logic [3:0] lcnt = 4'h0;
  initial demod_out = 1'b0;
  assign pll_lock = pll_en && lcnt == lock_dly;
  always @(posedge pclk) begin
    lcnt <= !pll_en ? 4'h0 : (pll_lock ? lcnt : lcnt + 4'h1);
    // Preburst never pauses, so it outlasts any sleep and start-up
    gcnt <= gcnt + 8'h01;
    if (gcnt + 8'h01 >= gap) begin
      gcnt <= 8'h00;
      demod_out <= ~demod_out;
    end
  end
endmodule
